// [hdl/xperipheral_enable_decode.sv]
// Extension-peripheral selection register and address steering
//
// How it works
// - First CAN bit gates first CAN access
// - First CAN off frees its two pins
// - First CAN window external only if all off
// - Second CAN bit gates second CAN access
// - Second CAN off frees its two pins
// - Second CAN window external only if all off
// - RAM bit picks on-chip RAM or external
// - Group bit enables ports, timer, mux
// - PWM bit gates PWM; window external rule
// - Whole shared range external when all off
// - Register resets to value 05h
// - Writes ignored after global enable set
`timescale 1ns/1ns
module xperipheral_enable_decode
    import xper_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Internal bus request from the CPU
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic [DATA_W-1:0] cpu_wdata,
    input wire logic [BE_W-1:0] cpu_be,
    // Global enable level from the system configuration register
    input wire logic global_extension_enable,
    // Register read answer
    output logic reg_ack,
    output logic [DATA_W-1:0] reg_rdata,
    // Steered access towards the units or the external interface
    output logic route_valid,
    output route_t route_target,
    output logic [ADDR_W-1:0] route_addr,
    output logic route_we,
    output logic [DATA_W-1:0] route_wdata,
    output logic [BE_W-1:0] route_be,
    // Unit enables
    output logic first_can_enable,
    output logic second_can_enable,
    output logic extension_ram_enable,
    output logic peripheral_group_enable,
    output logic extension_pwm_enable,
    // Port pin release and lock status
    output logic port4_pins_5_6_free,
    output logic port4_pins_4_7_free,
    output logic select_locked
);

    // Selection register state
    logic [DATA_W-1:0] extension_peripheral_select_reg;
    logic [DATA_W-1:0] extension_peripheral_select_next;
    logic lock_reg;
    logic lock_next;

    // Registered answer
    logic reg_ack_reg;
    logic [DATA_W-1:0] reg_rdata_reg;
    logic [DATA_W-1:0] reg_rdata_next;

    // Steering strobe and target
    logic route_valid_reg;
    route_t route_target_reg;
    route_t route_target_next;

    // Forwarded copies of the request
    logic [ADDR_W-1:0] route_addr_reg;
    logic route_we_reg;
    logic [DATA_W-1:0] route_wdata_reg;
    logic [BE_W-1:0] route_be_reg;

    // Decode wires
    logic [WIN_COUNT-1:0] win_hit;
    logic reg_hit;
    logic locked_now;
    logic reg_write;
    logic [DATA_W-1:0] lane_mask;
    logic [DATA_W-1:0] write_mask;
    logic shared_all_off;

    // Register access decode
    logic reg_access;
    logic reg_read;
    logic reg_write_req;

    // Enable bit views
    logic en_first_can;
    logic en_second_can;
    logic en_extension_ram;
    logic en_group;
    logic en_pwm;

    // Named per-unit hits
    logic hit_first_can;
    logic hit_second_can;
    logic hit_pwm;
    logic hit_shared_out;
    logic hit_shared_dead;
    logic hit_extension_ram;
    logic hit_group;

    // One comparator per steered window
    generate
        for (genvar w = 0; w < WIN_COUNT; w++) begin : g_win
            window_match #(
                .BASE(WIN_BASE[w]),
                .LIMIT(WIN_LIMIT[w])
            ) u_match (
                .addr(cpu_addr),
                .hit(win_hit[w])
            );
        end
    endgenerate

    // CAN enable bits of the stored register
    assign en_first_can = extension_peripheral_select_reg[FIRST_CAN_BIT];
    assign en_second_can = extension_peripheral_select_reg[SECOND_CAN_BIT];

    // Memory, group and PWM enable bits
    assign en_extension_ram = extension_peripheral_select_reg[EXTENSION_RAM_BIT];
    assign en_group = extension_peripheral_select_reg[GROUP_BIT];
    assign en_pwm = extension_peripheral_select_reg[PWM_BIT];

    // Register decode; reads return data, writes return zero
    assign reg_hit = (cpu_addr == SELECT_ADDR);
    assign reg_access = cpu_req & reg_hit;
    assign reg_read = reg_access & ~cpu_we;

    // Lock takes effect in the very cycle the global enable rises
    assign locked_now = lock_reg | global_extension_enable;

    // Lock flop sets on the enable and holds it until reset
    assign lock_next = lock_reg | global_extension_enable;

    // Write only while unlocked; a locked write is still acknowledged
    assign reg_write_req = reg_access & cpu_we;
    assign reg_write = reg_write_req & ~locked_now;

    // Byte lanes; only the low lane carries implemented bits
    assign lane_mask = {{(DATA_W-LOW_LANE_TOP-1){cpu_be[1]}}, {(LOW_LANE_TOP+1){cpu_be[0]}}};

    // Upper bits can never be written, so they always read zero
    assign write_mask = lane_mask & SELECT_WMASK;

    // Next register value, masked merge of write data
    assign extension_peripheral_select_next = reg_write
        ? ((extension_peripheral_select_reg & ~write_mask) | (cpu_wdata & write_mask))
        : extension_peripheral_select_reg;

    // Register readback, reserved bits forced low
    assign reg_rdata_next = extension_peripheral_select_reg & SELECT_WMASK;

    // Shared range goes out only when both CAN and PWM are off
    assign shared_all_off = ~en_first_can & ~en_second_can & ~en_pwm;

    // Window hits gated by each unit's enable bit
    assign hit_first_can = win_hit[WIN_FIRST_CAN] & en_first_can;
    assign hit_second_can = win_hit[WIN_SECOND_CAN] & en_second_can;
    assign hit_pwm = win_hit[WIN_PWM] & en_pwm;

    // Shared range goes out only when no unit in it is live
    assign hit_shared_out = win_hit[WIN_SHARED] & shared_all_off;

    // Disabled unit beside a live one: swallowed on chip
    assign hit_shared_dead = win_hit[WIN_SHARED] & ~shared_all_off;

    // Memory and group windows fall back to the external bus
    assign hit_extension_ram = win_hit[WIN_EXTENSION_RAM];
    assign hit_group = win_hit[WIN_GROUP];

    // Target selection; the order settles overlaps, register first
    assign route_target_next = reg_hit ? ROUTE_LOCAL
        : hit_first_can ? ROUTE_FIRST_CAN
        : hit_second_can ? ROUTE_SECOND_CAN
        : hit_pwm ? ROUTE_PWM
        : hit_shared_out ? ROUTE_EXTERNAL
        : hit_shared_dead ? ROUTE_NONE
        : hit_extension_ram ? (en_extension_ram ? ROUTE_EXTENSION_RAM : ROUTE_EXTERNAL)
        : hit_group ? (en_group ? ROUTE_GROUP : ROUTE_EXTERNAL)
        : ROUTE_NONE;

    // Selection register; reset loads the default
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            extension_peripheral_select_reg <= SELECT_RESET;
        end else begin
            extension_peripheral_select_reg <= extension_peripheral_select_next;
        end
    end

    // Sticky lock; only a reset reopens the register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lock_reg <= 1'b0;
        end else begin
            lock_reg <= lock_next;
        end
    end

    // Acknowledge one cycle after the request, writes too
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_ack_reg <= 1'b0;
        end else begin
            reg_ack_reg <= reg_access;
        end
    end

    // Read data; zero on writes so no stale value is seen
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata_reg <= '0;
        end else begin
            reg_rdata_reg <= reg_read ? reg_rdata_next : '0;
        end
    end

    // Steering strobe, one per request cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            route_valid_reg <= 1'b0;
        end else begin
            route_valid_reg <= cpu_req;
        end
    end

    // Steering target; idle cycles show no target
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            route_target_reg <= ROUTE_NONE;
        end else begin
            route_target_reg <= cpu_req ? route_target_next : ROUTE_NONE;
        end
    end

    // Forwarded address; held between requests to save toggling
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            route_addr_reg <= '0;
        end else if (cpu_req) begin
            route_addr_reg <= cpu_addr;
        end
    end

    // Forwarded direction
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            route_we_reg <= 1'b0;
        end else if (cpu_req) begin
            route_we_reg <= cpu_we;
        end
    end

    // Forwarded write data
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            route_wdata_reg <= '0;
        end else if (cpu_req) begin
            route_wdata_reg <= cpu_wdata;
        end
    end

    // Forwarded byte enables
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            route_be_reg <= '0;
        end else if (cpu_req) begin
            route_be_reg <= cpu_be;
        end
    end

    // Register answer outputs
    assign reg_ack = reg_ack_reg;
    assign reg_rdata = reg_rdata_reg;

    // Steering outputs, all straight from flops
    assign route_valid = route_valid_reg;
    assign route_target = route_target_reg;
    assign route_addr = route_addr_reg;
    assign route_we = route_we_reg;
    assign route_wdata = route_wdata_reg;
    assign route_be = route_be_reg;

    // CAN enables straight from the register
    assign first_can_enable = en_first_can;
    assign second_can_enable = en_second_can;

    // Memory, group and PWM enables
    assign extension_ram_enable = en_extension_ram;
    assign peripheral_group_enable = en_group;
    assign extension_pwm_enable = en_pwm;

    // First CAN pins go to general I/O when it is off
    assign port4_pins_5_6_free = ~en_first_can;

    // Second CAN pins likewise
    assign port4_pins_4_7_free = ~en_second_can;

    // Lock is sticky until reset; software must configure first
    assign select_locked = lock_reg;

endmodule : xperipheral_enable_decode

// [hdl/xper_pkg.sv]
// Constants and types for the extension-peripheral selection block
package xper_pkg;

    // Internal bus widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BE_W = 2;

    // Selection register location and contents
    localparam logic [ADDR_W-1:0] SELECT_ADDR = 24'h00F024;
    localparam logic [DATA_W-1:0] SELECT_RESET = 16'h0005;
    localparam logic [DATA_W-1:0] SELECT_WMASK = 16'h001F;
    localparam int FIRST_CAN_BIT = 0;
    localparam int SECOND_CAN_BIT = 1;
    localparam int EXTENSION_RAM_BIT = 2;
    localparam int GROUP_BIT = 3;
    localparam int PWM_BIT = 4;
    localparam int LOW_LANE = 0;
    localparam int LOW_LANE_TOP = 7;

    // Address windows, one entry per steered unit plus one for the shared range
    localparam int WIN_COUNT = 6;
    localparam int WIN_FIRST_CAN = 0;
    localparam int WIN_SECOND_CAN = 1;
    localparam int WIN_PWM = 2;
    localparam int WIN_EXTENSION_RAM = 3;
    localparam int WIN_GROUP = 4;
    localparam int WIN_SHARED = 5;
    localparam logic [ADDR_W-1:0] WIN_BASE [WIN_COUNT] = '{
        24'h00EF00, 24'h00EE00, 24'h00EC00, 24'h008000, 24'h00E800, 24'h00EC00
    };
    localparam logic [ADDR_W-1:0] WIN_LIMIT [WIN_COUNT] = '{
        24'h00EFFF, 24'h00EEFF, 24'h00ECFF, 24'h00BFFF, 24'h00EBFF, 24'h00EFFF
    };

    // Where one internal bus access is sent
    typedef enum logic [2:0] {
        ROUTE_NONE,
        ROUTE_LOCAL,
        ROUTE_FIRST_CAN,
        ROUTE_SECOND_CAN,
        ROUTE_EXTENSION_RAM,
        ROUTE_GROUP,
        ROUTE_PWM,
        ROUTE_EXTERNAL
    } route_t;

endpackage : xper_pkg

// [hdl/window_match.sv]
// Inclusive address window comparator
`timescale 1ns/1ns
module window_match
    import xper_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BASE = 24'h000000,
    parameter logic [ADDR_W-1:0] LIMIT = 24'h000000
) (
    // Address under test
    input wire logic [ADDR_W-1:0] addr,
    // Match result
    output logic hit
);

    // Both bounds inclusive
    assign hit = (addr >= BASE) && (addr <= LIMIT);

endmodule : window_match

// [test/xper_chk.sv]
// Checker for the selection register and address steering
`timescale 1ns/1ns
module xper_chk
    import xper_pkg::*;
(
    // Clock, reset and request
    input wire logic core_clk, reset, cpu_req, cpu_we, global_extension_enable,
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic [DATA_W-1:0] cpu_wdata, reg_rdata,
    input wire logic [BE_W-1:0] cpu_be,
    // Answers and levels
    input wire logic reg_ack, route_valid, select_locked,
    input wire route_t route_target,
    input wire logic first_can_enable, second_can_enable, extension_ram_enable,
    input wire logic peripheral_group_enable, extension_pwm_enable,
    input wire logic port4_pins_5_6_free, port4_pins_4_7_free
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Register view and window hits
    wire logic [4:0] en = {extension_pwm_enable, peripheral_group_enable,
        extension_ram_enable, second_can_enable, first_can_enable};
    wire logic sel = cpu_req && cpu_addr == SELECT_ADDR;
    wire logic c1 = cpu_req && cpu_addr[23:8] == 16'h00EF;
    wire logic shr = cpu_req && cpu_addr[23:10] == 14'h003B;
    wire logic xr = cpu_req && cpu_addr[23:14] == 10'h002;
    wire logic grp = cpu_req && cpu_addr[23:10] == 14'h003A;
    // An unlocked write with the low lane on
    sequence s_free_write;
        sel && cpu_we && cpu_be[0] && !global_extension_enable && !select_locked;
    endsequence
    a_write_taken: assert property (s_free_write |=> en == $past(cpu_wdata[4:0]))
        else $error("select write not taken");
    a_lock_holds: assert property ((global_extension_enable || select_locked) |=> $stable(en))
        else $error("select changed while locked");
    a_reg_answer: assert property (sel |=> reg_ack && route_valid && route_target == ROUTE_LOCAL)
        else $error("register access not answered");
    a_upper_zero: assert property (reg_ack |-> reg_rdata[15:5] == 11'h000)
        else $error("upper bits not zero");
    a_reset_value: assert property ($fell(reset) |-> en == 5'h05)
        else $error("wrong value after reset");
    a_can1_route: assert property (c1 && en[0] |=> route_target == ROUTE_FIRST_CAN)
        else $error("first CAN access misrouted");
    a_shared_ext: assert property (shr && !en[0] && !en[1] && !en[4] |=> route_target == ROUTE_EXTERNAL)
        else $error("shared range not external");
    a_ram_route: assert property (xr |=> route_target == ($past(en[2]) ? ROUTE_EXTENSION_RAM : ROUTE_EXTERNAL))
        else $error("RAM access misrouted");
    a_group_route: assert property (grp |=> route_target == ($past(en[3]) ? ROUTE_GROUP : ROUTE_EXTERNAL))
        else $error("group access misrouted");
    a_pins_first: assert property (port4_pins_5_6_free == !en[0])
        else $error("first CAN pins wrong");
    a_pins_second: assert property (port4_pins_4_7_free == !en[1])
        else $error("second CAN pins wrong");
endmodule : xper_chk

bind xperipheral_enable_decode xper_chk chk_u (.core_clk, .reset, .cpu_req, .cpu_we,
    .global_extension_enable, .cpu_addr, .cpu_wdata, .reg_rdata, .cpu_be, .reg_ack,
    .route_valid, .select_locked, .route_target, .first_can_enable, .second_can_enable,
    .extension_ram_enable, .peripheral_group_enable, .extension_pwm_enable,
    .port4_pins_5_6_free, .port4_pins_4_7_free);

// [test/cpu_model.sv]
// CPU model issuing single internal bus accesses
`timescale 1ns/1ns
module cpu_model
    import xper_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Request lines
    output logic cpu_req = 1'b0,
    output logic cpu_we = 1'b0,
    output logic global_extension_enable = 1'b0,
    output logic [ADDR_W-1:0] cpu_addr = '0,
    output logic [DATA_W-1:0] cpu_wdata = '0,
    output logic [BE_W-1:0] cpu_be = '0
);
    // One access; address and data lines scrambled after so stale values never pass
    task automatic access(input logic we, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
        @(posedge core_clk);
        cpu_req <= 1'b1;
        cpu_we <= we;
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_be <= be;
        @(posedge core_clk);
        cpu_req <= 1'b0;
        cpu_addr <= ~a;
        cpu_wdata <= ~d;
    endtask : access
    // Global enable set only after the selection is configured
    task automatic set_global(input logic v);
        @(posedge core_clk);
        global_extension_enable <= v;
    endtask : set_global
endmodule : cpu_model

// [test/xperipheral_enable_decode_tb.sv]
// Self-checking bench for the selection register and steering
`timescale 1ns/1ns
module xperipheral_enable_decode_tb
    import xper_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cpu_req, cpu_we, global_extension_enable, reg_ack, route_valid, route_we, locked;
    logic [ADDR_W-1:0] cpu_addr, route_addr;
    logic [DATA_W-1:0] cpu_wdata, reg_rdata, route_wdata;
    logic [BE_W-1:0] cpu_be, route_be;
    logic [4:0] en;
    logic [1:0] free;
    route_t route_target;
    int err_count = 0;
    int n_checks = 0;
    always #4 core_clk = ~core_clk;
    cpu_model cpu_u (.core_clk(core_clk), .cpu_req(cpu_req), .cpu_we(cpu_we),
        .global_extension_enable(global_extension_enable), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_be(cpu_be));
    xperipheral_enable_decode dut_u (.core_clk(core_clk), .reset(reset), .cpu_req(cpu_req),
        .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_be(cpu_be),
        .global_extension_enable(global_extension_enable), .reg_ack(reg_ack),
        .reg_rdata(reg_rdata), .route_valid(route_valid), .route_target(route_target),
        .route_addr(route_addr), .route_we(route_we), .route_wdata(route_wdata),
        .route_be(route_be),
        .first_can_enable(en[0]), .second_can_enable(en[1]), .extension_ram_enable(en[2]),
        .peripheral_group_enable(en[3]), .extension_pwm_enable(en[4]),
        .port4_pins_5_6_free(free[0]), .port4_pins_4_7_free(free[1]), .select_locked(locked));
    // Compare helpers
    task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_route(input route_t got, input route_t exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_route
    // Access, then look at the registered answer one cycle later
    task automatic go(input logic we, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
        cpu_u.access(we, a, d, be);
        #1;
    endtask : go
    task automatic rd(input logic [DATA_W-1:0] exp);
        go(1'b0, SELECT_ADDR, 16'h0000, 2'h3);
        chk({15'h0, reg_ack}, 16'h0001);
        chk(reg_rdata, exp);
        chk({11'h0, en}, exp);
    endtask : rd
    task automatic rt(input logic [ADDR_W-1:0] a, input route_t exp);
        go(1'b0, a, a[DATA_W-1:0], 2'h3);
        chk({15'h0, route_valid}, 16'h0001);
        chk_route(route_target, exp);
        chk(route_addr, a);
        chk(route_wdata, a[DATA_W-1:0]);
        chk({route_we, route_be}, 3'h3);
    endtask : rt
    // Scenarios
    task automatic t_after_reset;
        rd(16'h0005);
        chk({14'h0, free}, 16'h0002);
        chk({15'h0, locked}, 16'h0000);
        rt(24'h00EF10, ROUTE_FIRST_CAN);
        rt(24'h00EE10, ROUTE_NONE);
        rt(24'h00EC10, ROUTE_NONE);
        rt(24'h008000, ROUTE_EXTENSION_RAM);
        rt(24'h00EBFF, ROUTE_EXTERNAL);
    endtask : t_after_reset
    task automatic t_all_on;
        go(1'b1, SELECT_ADDR, 16'hFFFF, 2'h3);
        chk({route_we, route_be}, 3'h7);
        rd(16'h001F);
        chk({14'h0, free}, 16'h0000);
        rt(24'h00EEFF, ROUTE_SECOND_CAN);
        rt(24'h00EC00, ROUTE_PWM);
        rt(24'h00E800, ROUTE_GROUP);
        rt(24'h00BFFF, ROUTE_EXTENSION_RAM);
    endtask : t_all_on
    task automatic t_all_off;
        go(1'b1, SELECT_ADDR, 16'h0000, 2'h3);
        rd(16'h0000);
        chk({14'h0, free}, 16'h0003);
        rt(24'h00EF00, ROUTE_EXTERNAL);
        rt(24'h00EE00, ROUTE_EXTERNAL);
        rt(24'h00ECFF, ROUTE_EXTERNAL);
        rt(24'h00ED80, ROUTE_EXTERNAL);
        rt(24'h008000, ROUTE_EXTERNAL);
        go(1'b1, SELECT_ADDR, 16'h001F, 2'h2);
        rd(16'h0000);
    endtask : t_all_off
    task automatic t_lock;
        cpu_u.set_global(1'b1);
        go(1'b1, SELECT_ADDR, 16'h001F, 2'h3);
        chk({15'h0, locked}, 16'h0001);
        rd(16'h0000);
        rt(24'h00EF10, ROUTE_EXTERNAL);
    endtask : t_lock
    // Second reset in mid-run: default back, lock cleared, writes land
    task automatic t_reset_again;
        @(posedge core_clk);
        reset <= 1'b1;
        cpu_u.set_global(1'b0);
        @(posedge core_clk);
        reset <= 1'b0;
        rd(16'h0005);
        chk({15'h0, locked}, 16'h0000);
        rt(24'h00EF10, ROUTE_FIRST_CAN);
        go(1'b1, SELECT_ADDR, 16'h0012, 2'h1);
        rd(16'h0012);
    endtask : t_reset_again
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // Main sequence; the delay below cuts a hang short
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        t_after_reset();
        t_all_on();
        t_all_off();
        t_lock();
        t_reset_again();
        end_of_test();
    end
    initial begin
        #100000;
        err_count++;
        end_of_test();
    end
endmodule : xperipheral_enable_decode_tb
